/* rtl/aop_pkg.sv */
// Constants shared by the converter output and status pin logic.
// Assumes a 25 MHz reference clock and 8-bit register addresses and data.
package aop_pkg;

    // Clock and timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int CAL_TIME_NS = 2000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OUT_HALF_NS = 80;
    localparam int OUT_HALF_CYCLES = (OUT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POSTPROC_STAGES = 2;

    // Data widths.
    localparam int SAMPLE_W = 14;
    localparam int PAIRS = SAMPLE_W / 2;
    localparam int FIFO_DEPTH = 8;

    // Register offsets.
    localparam logic [7:0] OFS_PHASE_A = 8'h52;
    localparam logic [7:0] OFS_FORMAT = 8'h62;
    localparam logic [7:0] OFS_PHASE_B = 8'h64;
    localparam logic [7:0] OFS_POL_A = 8'h65;
    localparam logic [7:0] OFS_POL_B = 8'h68;
    localparam logic [7:0] OFS_PHASE_C = 8'h6d;

    // Reset values.
    localparam logic [7:0] RST_PHASE_A = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h00;
    localparam logic [7:0] RST_PHASE_B = 8'h00;
    localparam logic [7:0] RST_POL_A = 8'h00;
    localparam logic [7:0] RST_POL_B = 8'h00;
    localparam logic [7:0] RST_PHASE_C = 8'h00;

    // Field positions.
    localparam int FLD_ORDER_LSB = 0;
    localparam int FLD_DDR = 2;
    localparam int FLD_IQ = 3;
    localparam int FLD_POSTPROC_EN = 7;
    localparam int FLD_PHASE_LSB = 0;
    localparam int FLD_INV_DATA = 0;
    localparam int FLD_INV_CLK = 1;
    localparam int FLD_INV_RANGE = 0;
    localparam int FLD_INV_WORDCLK = 1;

    // Output ordering codes.
    localparam logic [1:0] ORDER_EVEN_FIRST = 2'h0;
    localparam logic [1:0] ORDER_ODD_FIRST = 2'h1;

    // Calibration states.
    typedef enum logic [1:0] {
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b10
    } aop_cal_e;

endpackage : aop_pkg

/* rtl/aop_reg_store.sv */
// Holds the six output control registers and answers reads.
// Assumes a single-cycle write strobe and read strobe from the serial port logic.
`timescale 1ns/100ps
module aop_reg_store
    import aop_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic [7:0] phaseA,
    output logic [7:0] format,
    output logic [7:0] phaseB,
    output logic [7:0] polA,
    output logic [7:0] polB,
    output logic [7:0] phaseC
);

    // Writes land in the addressed register; reset reloads every default.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phaseA <= RST_PHASE_A;
            format <= RST_FORMAT;
            phaseB <= RST_PHASE_B;
            polA <= RST_POL_A;
            polB <= RST_POL_B;
            phaseC <= RST_PHASE_C;
        end else if (regWrEn) begin
            case (regAddr)
                OFS_PHASE_A: phaseA <= regWrData;
                OFS_FORMAT: format <= regWrData;
                OFS_PHASE_B: phaseB <= regWrData;
                OFS_POL_A: polA <= regWrData;
                OFS_POL_B: polB <= regWrData;
                OFS_PHASE_C: phaseC <= regWrData;
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped addresses read as zero.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                OFS_PHASE_A: regRdData <= phaseA;
                OFS_FORMAT: regRdData <= format;
                OFS_PHASE_B: regRdData <= phaseB;
                OFS_POL_A: regRdData <= polA;
                OFS_POL_B: regRdData <= polB;
                OFS_PHASE_C: regRdData <= phaseC;
                default: regRdData <= 8'h00;
            endcase
        end
    end

endmodule : aop_reg_store

/* rtl/aop_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on ref_clk; head word is shown ahead of the pop.
`timescale 1ns/100ps
module aop_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign inReady = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Storage has no reset; only the pointers need a defined state.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers wrap at the depth, which is a power of two.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : aop_fifo

/* rtl/aop_output_pins.sv */
// Output and status pin logic of a 14-bit pipelined converter.
// Assumes the sample clock and all converter-core signals arrive from outside
// the ref_clk domain, and the serial port logic drives the register port.
//
// Operation
// - Everything stays in reset while reset_n is held low.
// - Leaving reset loads register defaults and starts the power-up calibration.
// - Calibration-done is low after power-up, high after first calibration finishes.
// - Flag stays high until hardware or soft-reset restart; low in reset.
// - Standby and shutdown freeze the calibration-done flag at its prior level; a restart in either mode still clears it.
// - Upper address bit reads zero; lower bit held while chip select low.
// - DDR mode puts two bits per pair; even-bit-first is the default ordering.
// - Even-first shows even bit while clock high, odd bit while low.
// - Overrange output is high while input overrange is detected.
// - With post-processing on, overrange leads its data words by the latency.
// - In I/Q mode word clock is low, high while in-phase samples output.
// - Outside I/Q, positive shared pin is overrange, negative pin is zero.
// - I/Q single-ended: positive pin overrange, negative pin word clock.
// - I/Q DDR: pair shows overrange on clock high, word clock on low.
// - Forwarded clock phase set by post-processing and phase registers.
// - Output polarity is controlled by the two polarity registers.
// - Single-ended one bit per pin; pair n carries bits 2n and 2n+1.
// - Reset high means normal operation, reset low holds the device.
`timescale 1ns/100ps
module aop_output_pins
    import aop_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sampleClkIn,
    input wire logic [SAMPLE_W-1:0] sampleDataIn,
    input wire logic sampleInPhaseIn,
    input wire logic overrangeIn,
    input wire logic standbyMode,
    input wire logic shutdownMode,
    input wire logic hwCalRestart,
    input wire logic softResetCmd,
    input wire logic chipSelect_n,
    input wire logic deviceAddrBitLow,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic calibrationDone,
    output logic forwardedOutputClock,
    output logic [SAMPLE_W-1:0] dataPins,
    output logic sharedPinPos,
    output logic sharedPinNeg,
    output logic [1:0] deviceAddress,
    output logic sampleInReady
);

    localparam int PERIOD_CYCLES = 2 * OUT_HALF_CYCLES;
    localparam int FW = SAMPLE_W + 1;

    // Swaps the two bits of each pair so one rule drives both orderings.
    function automatic logic [SAMPLE_W-1:0] swapPairs(input logic [SAMPLE_W-1:0] w);
        logic [SAMPLE_W-1:0] r;
        r = '0;
        for (int i = 0; i < PAIRS; i++) begin
            r[2*i] = w[2*i+1];
            r[2*i+1] = w[2*i];
        end
        return r;
    endfunction : swapPairs

    logic [7:0] phaseA;
    logic [7:0] format;
    logic [7:0] phaseB;
    logic [7:0] polA;
    logic [7:0] polB;
    logic [7:0] phaseC;

    // Register store; reset_n low reloads every default.
    aop_reg_store aop_reg_store_i (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .phaseA(phaseA),
        .format(format),
        .phaseB(phaseB),
        .polA(polA),
        .polB(polB),
        .phaseC(phaseC)
    );

    logic ddrMode;
    logic iqMode;
    logic postProcOn;
    logic oddFirst;
    logic [1:0] phaseSel;
    assign ddrMode = format[FLD_DDR];
    assign iqMode = format[FLD_IQ];
    assign oddFirst = (format[FLD_ORDER_LSB +: 2] == ORDER_ODD_FIRST);
    assign postProcOn = phaseA[FLD_POSTPROC_EN];
    // Post-processing path picks its own phase setting.
    assign phaseSel = postProcOn ? phaseB[FLD_PHASE_LSB +: 2] : phaseC[FLD_PHASE_LSB +: 2];

    // Two-stage synchronisers for everything from outside this clock domain.
    logic [2:0] sclk_q;
    logic [SAMPLE_W+1:0] core1_q;
    logic [SAMPLE_W+1:0] core2_q;
    logic [1:0] adr_q;
    logic [1:0] cs_q;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sclk_q <= '0;
            core1_q <= '0;
            core2_q <= '0;
            adr_q <= '0;
            cs_q <= 2'h3;
        end else begin
            sclk_q <= {sclk_q[1:0], sampleClkIn};
            core1_q <= {overrangeIn, sampleInPhaseIn, sampleDataIn};
            core2_q <= core1_q;
            adr_q <= {adr_q[0], deviceAddrBitLow};
            cs_q <= {cs_q[0], chipSelect_n};
        end
    end

    logic sampleEvt;
    logic rangeSync;
    assign sampleEvt = sclk_q[1] && !sclk_q[2];
    assign rangeSync = core2_q[SAMPLE_W+1];

    // The lower address bit is caught only while chip select is high.
    logic addrLow_q;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addrLow_q <= 1'b0;
        end else if (cs_q[1]) begin
            addrLow_q <= adr_q[1];
        end
    end
    assign deviceAddress = {1'b0, addrLow_q};

    // Calibration sequencer; standby and shutdown freeze it in place, but a hardware or soft-reset restart still wins.
    aop_cal_e calState_q;
    logic [$clog2(CAL_CYCLES+1)-1:0] calCnt_q;
    logic calRestart;
    logic calHold;
    assign calRestart = hwCalRestart || softResetCmd;
    assign calHold = standbyMode || shutdownMode;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            calState_q <= CAL_RUN;
            calCnt_q <= '0;
        end else if (calRestart) begin
            calState_q <= CAL_RUN;
            calCnt_q <= '0;
        end else if (!calHold) begin
            case (calState_q)
                CAL_RUN: begin
                    if (calCnt_q == ($bits(calCnt_q))'(CAL_CYCLES - 1)) begin
                        calState_q <= CAL_DONE;
                    end
                    calCnt_q <= calCnt_q + 1'b1;
                end
                CAL_DONE: calState_q <= CAL_DONE;
                default: calState_q <= CAL_RUN;
            endcase
        end
    end
    assign calibrationDone = (calState_q == CAL_DONE);

    // Post-processing delays the data but not the overrange flag.
    logic [FW-1:0] postProc_q [POSTPROC_STAGES];
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < POSTPROC_STAGES; i++) begin
                postProc_q[i] <= '0;
            end
        end else if (sampleEvt) begin
            postProc_q[0] <= core2_q[FW-1:0];
            for (int i = 1; i < POSTPROC_STAGES; i++) begin
                postProc_q[i] <= postProc_q[i-1];
            end
        end
    end

    logic fifoOutValid;
    logic fifoPop;
    logic [FW-1:0] fifoOut;
    logic [FW-1:0] fifoIn;
    assign fifoIn = postProcOn ? postProc_q[POSTPROC_STAGES-1] : core2_q[FW-1:0];

    // Words dropped while full show up as sampleInReady low at the event.
    aop_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) aop_fifo_i (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .inValid(sampleEvt),
        .inReady(sampleInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOut)
    );

    // Output period counter; the clock is high in the first half.
    logic [$clog2(PERIOD_CYCLES)-1:0] phaseCnt_q;
    logic [$clog2(PERIOD_CYCLES)-1:0] phaseCnt_d;
    logic periodStart;
    logic clkHigh_d;
    assign periodStart = (phaseCnt_q == ($bits(phaseCnt_q))'(PERIOD_CYCLES - 1));
    assign phaseCnt_d = periodStart ? '0 : phaseCnt_q + 1'b1;
    assign clkHigh_d = (phaseCnt_d < ($bits(phaseCnt_d))'(OUT_HALF_CYCLES));
    // One word is taken at the start of each output period.
    assign fifoPop = periodStart && fifoOutValid;

    logic [FW-1:0] outWord_q;
    logic [FW-1:0] outWord_d;
    logic clkHigh_q;
    assign outWord_d = fifoPop ? fifoOut : outWord_q;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phaseCnt_q <= ($bits(phaseCnt_q))'(PERIOD_CYCLES - 1);
            outWord_q <= '0;
            clkHigh_q <= 1'b0;
        end else begin
            phaseCnt_q <= phaseCnt_d;
            outWord_q <= outWord_d;
            clkHigh_q <= clkHigh_d;
        end
    end

    // Pin values for the coming cycle, ordering and polarity applied.
    logic [SAMPLE_W-1:0] ordered;
    logic [SAMPLE_W-1:0] pins_d;
    logic [SAMPLE_W-1:0] dataInv;
    logic wordClk;
    logic rangeOut;
    logic wordClkOut;
    logic posD;
    logic negD;
    always_comb begin
        ordered = oddFirst ? swapPairs(outWord_d[SAMPLE_W-1:0]) : outWord_d[SAMPLE_W-1:0];
        dataInv = polA[FLD_INV_DATA] ? ~ordered : ordered;
        pins_d = dataInv;
        if (ddrMode) begin
            for (int i = 0; i < PAIRS; i++) begin
                // Positive pin carries the phase bit, negative its complement.
                pins_d[2*i+1] = clkHigh_d ? dataInv[2*i] : dataInv[2*i+1];
                pins_d[2*i] = ~pins_d[2*i+1];
            end
        end
        wordClk = iqMode && outWord_d[SAMPLE_W];
        rangeOut = rangeSync ^ polB[FLD_INV_RANGE];
        wordClkOut = wordClk ^ polB[FLD_INV_WORDCLK];
        if (!iqMode) begin
            posD = rangeOut;
            negD = 1'b0;
        end else if (!ddrMode) begin
            posD = rangeOut;
            negD = wordClkOut;
        end else begin
            posD = clkHigh_d ? rangeOut : wordClkOut;
            negD = ~posD;
        end
    end

    // Pins come from flip-flops; the clock is delayed by the phase setting.
    // Tap zero launches with the pins, so a high clock covers the even bits by default;
    // each further tap adds a quarter output period for receivers that want margin.
    logic [1:0] clkDly_q;
    logic [3:0] clkTap;
    assign clkTap = {clkDly_q, clkHigh_q, clkHigh_d};
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dataPins <= '0;
            sharedPinPos <= 1'b0;
            sharedPinNeg <= 1'b0;
            clkDly_q <= '0;
            forwardedOutputClock <= 1'b0;
        end else begin
            dataPins <= pins_d;
            sharedPinPos <= posD;
            sharedPinNeg <= negD;
            clkDly_q <= {clkDly_q[0], clkHigh_q};
            forwardedOutputClock <= clkTap[phaseSel] ^ polA[FLD_INV_CLK];
        end
    end

    a_cal_reset_low: assert property (
        @(posedge ref_clk) !reset_n |=> !calibrationDone)
        else $error("calibration flag high after reset");

    a_cal_done_time: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(calibrationDone) |-> $past(calCnt_q) == ($bits(calCnt_q))'(CAL_CYCLES - 1))
        else $error("calibration ended at wrong count");

    a_cal_hold_mode: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (calHold && !calRestart) |=> $stable(calibrationDone) && $stable(calCnt_q))
        else $error("calibration moved during standby");

    a_addr_high_zero: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !cs_q[1] |=> !deviceAddress[1] && $stable(deviceAddress))
        else $error("address changed while selected");

    a_ddr_even_high: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ($past(ddrMode) && !$past(oddFirst) && !$past(polA[FLD_INV_DATA]) && clkHigh_q)
        |-> dataPins[1] == outWord_q[0] && dataPins[0] == !outWord_q[0])
        else $error("even bit missing in high phase");

    a_range_follow: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ($past(!ddrMode) && $past(!polB[FLD_INV_RANGE])) |-> sharedPinPos == $past(rangeSync))
        else $error("overrange pin does not follow input");

    a_neg_zero_noniq: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $past(!iqMode) |-> !sharedPinNeg ##1 ($past(iqMode) || !sharedPinNeg))
        else $error("negative shared pin not zero");

    a_word_per_period: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        fifoPop |=> !fifoPop [*3])
        else $error("more than one word per period");

    a_wordclk_iq: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ($past(iqMode) && !$past(ddrMode) && !$past(polB[FLD_INV_WORDCLK]))
        |-> sharedPinNeg == outWord_q[SAMPLE_W])
        else $error("word clock does not follow in-phase words");

endmodule : aop_output_pins

/* sim/aop_capture_model.sv */
// Behavioural capture logic standing on the far side of the data pins.
// Assumes single-ended format at phase setting zero, so the word sits still at the clock fall.
`timescale 1ns/100ps
module aop_capture_model
    import aop_pkg::*;
(
    input wire logic forwardedOutputClock,
    input wire logic [SAMPLE_W-1:0] dataPins,
    output logic [SAMPLE_W-1:0] capturedWord
);
    // The forwarded clock is the only timing reference a real receiver has; it rises with
    // a new word, so its falling edge lands mid-word and avoids a race with the pins.
    always @(negedge forwardedOutputClock) begin
        capturedWord <= dataPins;
    end
endmodule : aop_capture_model

/* sim/aop_output_pins_tb.sv */
// Self-checking bench for the converter output and status pin block.
// Assumes the capture model on the far side and a 25 MHz reference clock.
`timescale 1ns/100ps
module aop_output_pins_tb
    import aop_pkg::*;
();
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sampleClkIn = 1'b0;
    logic [SAMPLE_W-1:0] sampleDataIn = '0;
    logic sampleInPhaseIn = 1'b0;
    logic overrangeIn = 1'b0;
    logic standbyMode = 1'b0;
    logic shutdownMode = 1'b0;
    logic hwCalRestart = 1'b0;
    logic softResetCmd = 1'b0;
    logic chipSelect_n = 1'b1;
    logic deviceAddrBitLow = 1'b0;
    logic [7:0] regAddr = '0;
    logic [7:0] regWrData = '0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic calibrationDone;
    logic forwardedOutputClock;
    logic [SAMPLE_W-1:0] dataPins;
    logic sharedPinPos;
    logic sharedPinNeg;
    logic [1:0] deviceAddress;
    logic sampleInReady;
    logic [SAMPLE_W-1:0] capturedWord;
    logic sawFull;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    int hi;
    logic [7:0] ofs [6] = '{OFS_PHASE_A, OFS_FORMAT, OFS_PHASE_B, OFS_POL_A, OFS_POL_B,
        OFS_PHASE_C};
    logic [7:0] dflt [6] = '{RST_PHASE_A, RST_FORMAT, RST_PHASE_B, RST_POL_A, RST_POL_B,
        RST_PHASE_C};

    aop_output_pins aop_output_pins_i (
        .ref_clk, .reset_n, .sampleClkIn, .sampleDataIn, .sampleInPhaseIn, .overrangeIn,
        .standbyMode, .shutdownMode, .hwCalRestart, .softResetCmd, .chipSelect_n,
        .deviceAddrBitLow, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
        .calibrationDone, .forwardedOutputClock, .dataPins, .sharedPinPos, .sharedPinNeg,
        .deviceAddress, .sampleInReady
    );

    aop_capture_model aop_capture_model_i (
        .forwardedOutputClock, .dataPins, .capturedWord
    );

    // Free-running 25 MHz reference clock.
    always #20 ref_clk = ~ref_clk;

    // Cut a hung run short; the whole sequence needs about 740 cycles.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge ref_clk);
        regWrEn = 1'b0;
    endtask : wr

    // Read data holds until the next read, so a late sample is safe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge ref_clk);
        regRdEn = 1'b0;
        @(negedge ref_clk);
        d = regRdData;
    endtask : rd

    // One sample event; the word stays put for a whole half period on each side of the rise.
    task automatic send(input logic [SAMPLE_W-1:0] w, input logic iq, input int halfNs);
        sampleDataIn = w;
        sampleInPhaseIn = iq;
        #(halfNs) sampleClkIn = 1'b1;
        #(halfNs) sampleClkIn = 1'b0;
    endtask : send

    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // Main sequence of tests.
    initial begin
        logic [7:0] d;
        cyc(12);
        check("calDone in reset", calibrationDone, 1'b0);
        reset_n = 1'b1;
        cyc(CAL_CYCLES - 2);
        check("calDone early", calibrationDone, 1'b0);
        cyc(5);
        check("calDone late", calibrationDone, 1'b1);
        softResetCmd = 1'b1;
        cyc(1);
        softResetCmd = 1'b0;
        cyc(3);
        check("calDone soft", calibrationDone, 1'b0);
        cyc(10);
        shutdownMode = 1'b1;
        cyc(CAL_CYCLES + 10);
        check("calDone shutdown", calibrationDone, 1'b0);
        shutdownMode = 1'b0;
        cyc(CAL_CYCLES);
        check("calDone resumed", calibrationDone, 1'b1);
        standbyMode = 1'b1;
        cyc(5);
        check("calDone standby", calibrationDone, 1'b1);
        hwCalRestart = 1'b1;
        cyc(1);
        hwCalRestart = 1'b0;
        cyc(CAL_CYCLES + 5);
        check("calDone hw", calibrationDone, 1'b0);
        standbyMode = 1'b0;
        cyc(CAL_CYCLES + 5);
        check("calDone again", calibrationDone, 1'b1);
        $display("test calibration done");

        deviceAddrBitLow = 1'b1;
        cyc(5);
        check("address", deviceAddress, 2'h1);
        chipSelect_n = 1'b0;
        cyc(5);
        check("address selected", deviceAddress, 2'h1);
        chipSelect_n = 1'b1;
        cyc(1);
        deviceAddrBitLow = 1'b0;
        cyc(5);
        check("address", deviceAddress, 2'h0);
        $display("test address done");

        send(14'h2a5c, 1'b0, 160);
        send(14'h1b3d, 1'b0, 160);
        cyc(12);
        check("cmos word", dataPins, 14'h1b3d);
        check("captured", capturedWord, 14'h1b3d);
        overrangeIn = 1'b1;
        cyc(6);
        check("range pos", sharedPinPos, 1'b1);
        check("range neg", sharedPinNeg, 1'b0);
        wr(OFS_POL_A, 8'h01);
        wr(OFS_POL_B, 8'h01);
        cyc(6);
        check("inv data", dataPins, 14'h24c2);
        check("inv range", sharedPinPos, 1'b0);
        overrangeIn = 1'b0;
        wr(OFS_POL_A, 8'h00);
        wr(OFS_POL_B, 8'h00);
        cyc(6);
        check("range clear", sharedPinPos, 1'b0);
        $display("test cmos done");

        wr(OFS_FORMAT, 8'h08);
        cyc(6);
        check("word clock idle", sharedPinNeg, 1'b0);
        send(14'h0101, 1'b1, 160);
        cyc(12);
        check("word clock in-phase", sharedPinNeg, 1'b1);
        send(14'h0202, 1'b0, 160);
        cyc(12);
        check("word clock quadrature", sharedPinNeg, 1'b0);
        $display("test iq cmos done");

        // Even bits all ones and odd bits all zeros make the two phases tell apart.
        wr(OFS_FORMAT, 8'h0c);
        overrangeIn = 1'b1;
        send(14'h1555, 1'b0, 160);
        cyc(12);
        hi = 0;
        repeat (8) begin
            @(negedge ref_clk);
            check("ddr shared", sharedPinPos, dataPins[1]);
            check("ddr neg", sharedPinNeg, !sharedPinPos);
            check("ddr clock", (dataPins & 14'h2aaa) == 14'h2aaa, forwardedOutputClock);
            check("ddr range", sharedPinPos, forwardedOutputClock);
            if ((dataPins & 14'h2aaa) === 14'h2aaa) hi++;
        end
        check("even cycles", 16'(hi), 16'd4);
        $display("test ddr done");

        wr(OFS_FORMAT, 8'h00);
        overrangeIn = 1'b0;
        sawFull = 1'b0;
        fork
            repeat (30) send(14'h0011, 1'b0, 40);
            repeat (70) begin
                @(negedge ref_clk);
                if (sampleInReady === 1'b0) sawFull = 1'b1;
            end
        join
        check("fifo refused", sawFull, 1'b1);
        cyc(60);
        check("fifo drained", sampleInReady, 1'b1);
        $display("test fifo done");

        wr(OFS_PHASE_A, 8'h80);
        send(14'h0aaa, 1'b0, 160);
        send(14'h0bbb, 1'b0, 160);
        send(14'h0ccc, 1'b0, 160);
        cyc(12);
        overrangeIn = 1'b1;
        cyc(6);
        check("post data", dataPins, 14'h0aaa);
        check("post range", sharedPinPos, 1'b1);
        overrangeIn = 1'b0;
        $display("test post-processing done");

        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 8'h5a ^ 8'(i));
            rd(ofs[i], d);
            check("reg rw", d, 8'h5a ^ 8'(i));
        end
        wr(8'h63, 8'hff);
        rd(8'h63, d);
        check("unmapped", d, 8'h00);
        $display("test registers done");

        reset_n = 1'b0;
        cyc(3);
        check("calDone reset", calibrationDone, 1'b0);
        check("pins reset", dataPins, 14'h0000);
        reset_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], d);
            check("reg default", d, dflt[i]);
        end
        cyc(CAL_CYCLES + 5);
        check("calDone final", calibrationDone, 1'b1);
        $display("test reset done");
        results();
    end
endmodule : aop_output_pins_tb
